/* sdb_diag.sv */
/*
 * Sensor diagnostic and burnout scheduler. Sequences channels, steers
 * burnout currents, clamps results and builds the diagnostic flags.
 * Assumes the converter core pulses conv_done_i once per conversion
 * and that register access strobes come from the same clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

// Contract
// RULE1 - Continuous scans go first to last, repeat
// RULE2 - Burnout only after channel conversion finished
// RULE3 - Burnout gated by per-channel enable, any mode
// RULE4 - Two 10 uA sources: source positive, sink negative
// RULE5 - Non-burnout modes inject all enabled channels
// RULE6 - Burnout mode steers to last sampled channel
// RULE7 - Software should prefer burnout scan mode
// RULE8 - Excitation select 100 to 1000 uA, 100 steps
// RULE9 - Short flag when result within threshold inclusive
// RULE10 - Eight-bit threshold compares result code magnitude
// RULE11 - Rail flag when input within 50 mV
// RULE12 - Power-on flag set by reset, cleared on read
// RULE13 - Two-bit overrange code, four conditions
// RULE14 - Saturate result to 7fff or 8000
// RULE15 - Channel field names previous conversion
// RULE16 - Flags, channel, result update together
module sdb_diag
  import sdb_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Scan configuration
  input  wire logic [1:0]           scan_mode_i,
  input  wire logic [2:0]           scan_start_channel_i,
  input  wire logic [2:0]           scan_end_channel_i,
  input  wire logic [6:0]           burnout_en_i,
  input  wire logic                 scan_start_i,
  // Excitation
  input  wire logic [3:0]           excitation_current_select_i,
  // Converter core
  input  wire logic                 conv_done_i,
  input  wire sdb_conv_t            conv_i,
  // Register access
  input  wire logic                 thld_wr_i,
  input  wire logic [7:0]           thld_wdata_i,
  input  wire logic                 flags_rd_i,
  // Outputs to analog and software
  output logic [2:0]                conv_channel_o,
  output logic                      scan_active_o,
  output logic [6:0]                burnout_source_pos_o,
  output logic [6:0]                burnout_sink_neg_o,
  output logic [3:0]                excitation_source_a_o,
  output logic [3:0]                excitation_source_b_o,
  output logic [15:0]               result_o,
  output logic [7:0]                sensor_diag_flag_reg_o,
  output logic [7:0]                short_threshold_level_o,
  output logic                      result_valid_o
);

  sdb_scan_mode_t mode;
  assign mode = sdb_scan_mode_t'(scan_mode_i);

  // Scan sequencer state
  logic [2:0]  ch_q, ch_d;
  logic        act_q, act_d;
  logic [6:0]  bo_q, bo_d;
  logic [3:0]  exc_q, exc_d;

  always_comb begin
    ch_d  = ch_q;
    act_d = act_q;
    bo_d  = bo_q;
    exc_d = (excitation_current_select_i > SDB_EXC_SEL_MAX) ?
            SDB_EXC_SEL_MAX : excitation_current_select_i; // RULE8
    if (scan_start_i) begin
      act_d = 1'b1;
      ch_d  = scan_start_channel_i;
      bo_d  = 7'h00;
    end else if (act_q && conv_done_i) begin
      case (mode)
        SDB_SCAN_SINGLE_CHANNEL: begin
          ch_d = scan_start_channel_i;
        end
        SDB_SCAN_MULTI_SINGLE: begin
          if (ch_q >= scan_end_channel_i) begin
            act_d = 1'b0;
          end else begin
            ch_d = ch_q + 3'h1;
          end
        end
        default: begin
          if (ch_q >= scan_end_channel_i) begin // RULE1
            ch_d = scan_start_channel_i;
          end else begin
            ch_d = ch_q + 3'h1;
          end
        end
      endcase
      // Hazard: inject only into the channel just finished
      bo_d = 7'h00;
      bo_d[ch_q] = burnout_en_i[ch_q]; // RULE2 RULE6
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch_q  <= 3'h0;
      act_q <= 1'b0;
      bo_q  <= 7'h00;
      exc_q <= 4'h0;
    end else begin
      ch_q  <= ch_d;
      act_q <= act_d;
      bo_q  <= bo_d;
      exc_q <= exc_d;
    end
  end

  logic [6:0] bo_live;
  always_comb begin
    if (mode == SDB_SCAN_CONTINUOUS_WITH_BURNOUT) begin
      bo_live = bo_q & burnout_en_i; // RULE3
    end else begin
      // Software keeps at most one enable in these modes
      bo_live = burnout_en_i; // RULE5 RULE3
    end
  end

  assign burnout_source_pos_o  = bo_live; // RULE4
  assign burnout_sink_neg_o    = bo_live; // RULE4
  assign excitation_source_a_o = exc_q;
  assign excitation_source_b_o = exc_q;
  assign conv_channel_o        = ch_q;
  assign scan_active_o         = act_q;

  // Result and flag state
  logic [15:0]  res_q, res_d;
  sdb_flags_t   flg_q, flg_d;
  logic [7:0]   thld_q, thld_d;
  logic         vld_q, vld_d;
  logic [17:0]  mag;
  logic         clamp_pos, clamp_neg;

  always_comb begin
    mag       = conv_i.raw[17] ? (18'h0 - conv_i.raw) : conv_i.raw;
    clamp_pos = !conv_i.raw[17] && (conv_i.raw > 18'h07fff);
    clamp_neg = conv_i.raw[17] && (conv_i.raw < 18'h38000);
    res_d  = res_q;
    flg_d  = flg_q;
    thld_d = thld_wr_i ? thld_wdata_i : thld_q; // RULE10
    vld_d  = 1'b0;
    // Read clears first so a same-cycle event still lands
    if (flags_rd_i) begin
      flg_d.power_on_since_read = 1'b0; // RULE12
    end
    if (conv_done_i && act_q) begin
      vld_d = 1'b1;
      // Modulator direction outranks the code clamp, matching the code
      if (conv_i.mod_pos) begin
        res_d = SDB_RES_POS_FS; // RULE14
      end else if (conv_i.mod_neg) begin
        res_d = SDB_RES_NEG_FS; // RULE14
      end else if (clamp_pos) begin
        res_d = SDB_RES_POS_FS; // RULE14
      end else if (clamp_neg) begin
        res_d = SDB_RES_NEG_FS; // RULE14
      end else begin
        res_d = conv_i.raw[15:0];
      end
      if (conv_i.mod_pos) begin
        flg_d.overrange_code = SDB_OVR_POS; // RULE13
      end else if (conv_i.mod_neg) begin
        flg_d.overrange_code = SDB_OVR_NEG; // RULE13
      end else if (clamp_pos || clamp_neg) begin
        flg_d.overrange_code = SDB_OVR_CLAMP; // RULE13
      end else begin
        flg_d.overrange_code = SDB_OVR_NONE; // RULE13
      end
      flg_d.short_detect_flag = (mag <= {10'h0, thld_q}); // RULE9 RULE10
      flg_d.rail_flag         = conv_i.near_rail; // RULE11
      flg_d.result_channel_id = ch_q; // RULE15 RULE16
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_q  <= 16'h0000;
      flg_q  <= sdb_flags_t'(SDB_FLAGS_RST); // RULE12
      thld_q <= SDB_THLD_RST;
      vld_q  <= 1'b0;
    end else begin
      res_q  <= res_d;
      flg_q  <= flg_d;
      thld_q <= thld_d;
      vld_q  <= vld_d;
    end
  end

  assign result_o                = res_q;
  assign sensor_diag_flag_reg_o  = flg_q;
  assign short_threshold_level_o = thld_q;
  assign result_valid_o          = vld_q;

  // Checks
  AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    (act_q && conv_done_i && !scan_start_i && ch_q >= scan_end_channel_i
     && mode == SDB_SCAN_MULTI_CONTINUOUS) |=> ch_q == $past(scan_start_channel_i))
    else $error("Scan did not wrap to start channel");
  AST_BO_AFTER: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    (act_q && conv_done_i && !scan_start_i) |=>
      bo_q == ((7'h01 << $past(ch_q)) & $past(burnout_en_i)))
    else $error("Burnout not steered to finished channel");
  AST_BO_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    (burnout_source_pos_o & ~burnout_en_i) == 7'h00)
    else $error("Burnout on disabled channel");
  AST_BO_PAIR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    burnout_source_pos_o == burnout_sink_neg_o)
    else $error("Burnout sources disagree");
  AST_BO_ALL: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    mode != SDB_SCAN_CONTINUOUS_WITH_BURNOUT |->
      burnout_source_pos_o == burnout_en_i)
    else $error("Enabled channel not injected");
  AST_BO_ONE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    mode == SDB_SCAN_CONTINUOUS_WITH_BURNOUT |-> $onehot0(bo_live))
    else $error("More than one burnout channel");
  AST_EXC: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    ##1 exc_q <= SDB_EXC_SEL_MAX)
    else $error("Excitation select out of range");
  AST_SHORT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    (conv_done_i && act_q) |=> flg_q.short_detect_flag == ($past(mag) <=
      {10'h0, $past(thld_q)}))
    else $error("Short flag wrong");
  AST_RAIL: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    (conv_done_i && act_q) |=> flg_q.rail_flag == $past(conv_i.near_rail))
    else $error("Rail flag wrong");
  AST_POR_CLR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    flags_rd_i |=> !flg_q.power_on_since_read)
    else $error("Power-on flag not cleared by read");
  AST_OVR: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    (conv_done_i && act_q && conv_i.mod_neg && !conv_i.mod_pos) |=>
      flg_q.overrange_code == SDB_OVR_NEG && res_q == SDB_RES_NEG_FS)
    else $error("Negative overrange not reported");
  AST_CLAMP: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    (conv_done_i && act_q && !conv_i.mod_pos && !conv_i.mod_neg && clamp_pos)
      |=> res_q == SDB_RES_POS_FS && flg_q.overrange_code == SDB_OVR_CLAMP)
    else $error("Positive clamp wrong");
  AST_CHAN: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
    (conv_done_i && act_q) |=> flg_q.result_channel_id == $past(ch_q))
    else $error("Result channel wrong");
  AST_TOGETHER: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
    $changed(res_q) |-> result_valid_o)
    else $error("Result changed without flags");

  COV_WRAP: cover property (@(posedge clk_i) disable iff (rst_i)
    act_q && conv_done_i && ch_q == scan_end_channel_i);
  COV_BO: cover property (@(posedge clk_i) disable iff (rst_i)
    mode == SDB_SCAN_CONTINUOUS_WITH_BURNOUT && bo_live != 7'h00);
  COV_SHORT: cover property (@(posedge clk_i) disable iff (rst_i)
    flg_q.short_detect_flag);
  COV_POR_RD: cover property (@(posedge clk_i) disable iff (rst_i)
    flags_rd_i && flg_q.power_on_since_read);

endmodule

`default_nettype wire

/* sdb_pkg.sv */
/*
 * Package for the sensor diagnostic and burnout block: scan modes,
 * field layouts, reset values and the packed carriers it uses.
 * Assumes one 10 MHz clock domain shared with the converter core.
 */
package sdb_pkg;

  localparam int unsigned SDB_NUM_CH     = 7;
  localparam int unsigned SDB_CH_W       = 3;
  localparam int unsigned SDB_RES_W      = 16;

  // Burnout source strength, microamps
  localparam int unsigned SDB_BURNOUT_UA = 10;

  // Excitation current, microamps
  localparam int unsigned SDB_EXC_MIN_UA  = 100;
  localparam int unsigned SDB_EXC_MAX_UA  = 1000;
  localparam int unsigned SDB_EXC_STEP_UA = 100;
  localparam int unsigned SDB_EXC_SEL_W   = 4;
  localparam logic [3:0]  SDB_EXC_SEL_MAX = 4'h9;

  // Near-rail window, millivolts
  localparam int unsigned SDB_RAIL_MV    = 50;

  // Flag register layout
  localparam int unsigned SDB_FLG_CH_LSB  = 0;
  localparam int unsigned SDB_FLG_OVR_LSB = 3;
  localparam int unsigned SDB_FLG_POR_BIT = 5;
  localparam int unsigned SDB_FLG_RAIL_BIT = 6;
  localparam int unsigned SDB_FLG_SHRT_BIT = 7;

  localparam logic [7:0]  SDB_THLD_RST   = 8'h00;
  localparam logic [7:0]  SDB_FLAGS_RST  = 8'h20;

  // Overrange codes
  localparam logic [1:0]  SDB_OVR_NONE   = 2'h0;
  localparam logic [1:0]  SDB_OVR_CLAMP  = 2'h1;
  localparam logic [1:0]  SDB_OVR_POS    = 2'h2;
  localparam logic [1:0]  SDB_OVR_NEG    = 2'h3;

  localparam logic [15:0] SDB_RES_POS_FS = 16'h7fff;
  localparam logic [15:0] SDB_RES_NEG_FS = 16'h8000;

  typedef enum logic [1:0] {
    SDB_SCAN_SINGLE_CHANNEL,
    SDB_SCAN_MULTI_SINGLE,
    SDB_SCAN_MULTI_CONTINUOUS,
    SDB_SCAN_CONTINUOUS_WITH_BURNOUT
  } sdb_scan_mode_t;

  // Raw end-of-conversion report from the converter core
  typedef struct packed {
    logic [17:0] raw;       // Two's complement, before clamping
    logic        mod_pos;   // Modulator overrange toward +ref
    logic        mod_neg;   // Modulator overrange toward -ref
    logic        near_rail; // Comparator: input within rail window
  } sdb_conv_t;

  typedef struct packed {
    logic        short_detect_flag;
    logic        rail_flag;
    logic        power_on_since_read;
    logic [1:0]  overrange_code;
    logic [2:0]  result_channel_id;
  } sdb_flags_t;

endpackage

/* sdb_conv_model.sv */
/*
 * Converter core and sensor model facing the diagnostic block.
 * Assumes requests arrive just after a rising edge of clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module sdb_conv_model
  import sdb_pkg::*;
(
  // Clock and request
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire sdb_conv_t  val_i,
  input  wire logic [3:0] wait_i,
  // Sensor side
  input  wire logic [2:0] conv_channel_i,
  input  wire logic [6:0] burnout_i,
  // Answer to the block
  output logic            done_o,
  output sdb_conv_t       conv_o
);
  logic [4:0] cnt_q = 5'h00;
  logic       hit_q = 1'b0;
  // Open sensor pulled to a rail when burnout disturbs a conversion
  always_ff @(posedge clk_i) begin
    if (go_i) begin
      cnt_q <= {1'b0, wait_i} + 5'h01;
      hit_q <= 1'b0;
    end else begin
      if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
      if (burnout_i[conv_channel_i]) hit_q <= 1'b1;
    end
  end
  assign done_o = (cnt_q == 5'h01);
  // Stale data never shown outside the answer cycle
  assign conv_o = done_o ? (val_i | {20'h0, hit_q}) : ~val_i;
endmodule
`default_nettype wire

/* sdb_diag_tb.sv */
/*
 * Self-checking bench for sdb_diag: scan order, burnout steering,
 * flags and clamping. Assumes sdb_conv_model plays the core.
 */
`timescale 1ns/100ps
`default_nettype none
module sdb_diag_tb
  import sdb_pkg::*;
  ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] mode;
  logic [2:0] s_ch, e_ch, ch, exp_ch;
  logic [6:0] en, bp, bn;
  logic start, go, done, thr_wr, rd, act, vld, po;
  logic [3:0] exc, wt, ea, eb;
  logic [7:0] thr, flg, lvl;
  logic [15:0] res;
  sdb_conv_t cv, val;
  sdb_conv_t tv [8];
  int n_mismatch = 0, check_count = 0, cyc = 0, i, m;
  sdb_diag dut_u (.clk_i(clk_i), .rst_i(rst_i), .scan_mode_i(mode),
    .scan_start_channel_i(s_ch), .scan_end_channel_i(e_ch),
    .burnout_en_i(en), .scan_start_i(start),
    .excitation_current_select_i(exc), .conv_done_i(done), .conv_i(cv),
    .thld_wr_i(thr_wr), .thld_wdata_i(thr), .flags_rd_i(rd),
    .conv_channel_o(ch), .scan_active_o(act), .burnout_source_pos_o(bp),
    .burnout_sink_neg_o(bn), .excitation_source_a_o(ea),
    .excitation_source_b_o(eb), .result_o(res),
    .sensor_diag_flag_reg_o(flg), .short_threshold_level_o(lvl),
    .result_valid_o(vld));
  sdb_conv_model core_u (.clk_i(clk_i), .go_i(go), .val_i(val),
    .wait_i(wt), .conv_channel_i(ch), .burnout_i(bp), .done_o(done),
    .conv_o(cv));
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic pulse_start();
    exp_ch = s_ch;
    start = 1'b1;
    tick();
    start = 1'b0;
    chk(ch, s_ch);
  endtask
  function automatic logic [23:0] model_of(sdb_conv_t c, logic [2:0] sc);
    logic signed [17:0] r;
    logic [17:0] mg;
    logic [1:0] ov;
    logic [15:0] v;
    r = c.raw;
    mg = (r < 0) ? -r : r;
    ov = c.mod_pos ? SDB_OVR_POS : c.mod_neg ? SDB_OVR_NEG :
         (r > 32767 || r < -32768) ? SDB_OVR_CLAMP : SDB_OVR_NONE;
    v = (ov == SDB_OVR_NONE) ? r[15:0] : (ov == SDB_OVR_NEG ||
        (ov == SDB_OVR_CLAMP && r < 0)) ? SDB_RES_NEG_FS : SDB_RES_POS_FS;
    return {v, (mg <= {10'h0, thr}), c.near_rail, po, ov, sc};
  endfunction
  task automatic conv(input sdb_conv_t v, input logic [3:0] w);
    logic [2:0] old;
    logic [6:0] b;
    int k;
    old = exp_ch;
    val = v;
    wt = w;
    go = 1'b1;
    tick();
    go = 1'b0;
    chk(vld, 1'b0);
    for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge clk_i);
    tick();
    b = (mode == 2'h3) ? (en & (7'h01 << old)) : en;
    exp_ch = (mode == 2'h0) ? old : (old == e_ch) ? s_ch : old + 3'h1;
    chk({res, flg}, model_of(v, old));
    chk(vld, 1'b1);
    chk({bp, bn}, {b, b});
    if (act === 1'b1) chk(ch, exp_ch);
  endtask
  initial begin
    mode = 2'h0; s_ch = 3'h0; e_ch = 3'h0; en = 7'h00; start = 1'b0;
    exc = 4'h0; thr_wr = 1'b0; thr = 8'h00; rd = 1'b0; go = 1'b0;
    val = '0; wt = 4'h0; po = 1'b1; exp_ch = 3'h0;
    repeat (3) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    chk(flg, SDB_FLAGS_RST);
    chk(lvl, SDB_THLD_RST);
    thr = 8'h10;
    thr_wr = 1'b1;
    tick();
    thr_wr = 1'b0;
    chk(lvl, thr);
    for (i = 0; i < 16; i++) begin
      exc = i[3:0];
      tick();
      chk({ea, eb}, (i > 9) ? 8'h99 : {2{i[3:0]}});
    end
    // Boundaries of short window, clamps and every overrange code
    tv = '{{18'h00010, 3'h0}, {18'h3fff0, 3'h0}, {18'h00011, 3'h1},
           {18'h08000, 3'h0}, {18'h37fff, 3'h0}, {18'h00100, 3'h4},
           {18'h3ff00, 3'h2}, {18'h00005, 3'h0}};
    // Background burnout mode preferred by software
    mode = 2'h3;
    s_ch = 3'h2;
    e_ch = 3'h4;
    en = 7'h08;
    pulse_start();
    for (i = 0; i < 8; i++) begin
      if (i == 4) begin
        rd = 1'b1;
        tick();
        rd = 1'b0;
        po = 1'b0;
        chk(flg[5], 1'b0);
      end
      conv(tv[i], 4'(i % 3));
    end
    // Only one enabled channel outside the burnout mode
    en = 7'h20;
    for (m = 0; m < 3; m++) begin
      mode = m[1:0];
      pulse_start();
      repeat (3) conv(tv[7], 4'h1);
      if (m == 1) chk(act, 1'b0);
    end
    rst_i = 1'b1;
    tick();
    rst_i = 1'b0;
    chk(flg, SDB_FLAGS_RST);
    give_verdict();
  end
endmodule
`default_nettype wire
